// [verilog/cpls_top.sv]
// CPU priority level status registers with AHB-Lite access
`timescale 1ns/1ps
`default_nettype none
`include "cpls_params.svh"
module cpls_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Core level updates
  input wire cpls_pkg::cpls_core_upd_t core_upd,
  // User interrupt request
  input wire cpls_pkg::cpls_user_req_t user_req,
  // Status towards the core
  output logic irq_forward,
  output logic [3:0] cpu_level,
  output logic variable_latency,
  output logic nesting_disable
);
  import cpls_pkg::*;

  cpls_acc_t acc;
  logic [15:0] rdata;
  logic allow;
  logic [2:0] priority_level_low_bits_r;
  logic priority_level_high_bit_r;
  logic var_latency_r;
  logic nesting_disable_r;
  logic wr_status;
  logic wr_core;
  logic wr_trap;

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  // Only whole-word transfers are used, so hsize is not decoded
  cpls_ahb_slave u_slave (
    .clock(clock),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .acc(acc),
    .rdata(rdata)
  );

  // Write strobes per register; unmapped writes fall through
  assign wr_status = acc.valid && acc.write && acc.addr == `CPLS_OFS_STATUS;
  assign wr_core = acc.valid && acc.write && acc.addr == `CPLS_OFS_CORE;
  assign wr_trap = acc.valid && acc.write && acc.addr == `CPLS_OFS_TRAP;

  // ---------------------------------------------------------------
  // Priority level low bits
  // ---------------------------------------------------------------
  // Core update wins over a software write in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      priority_level_low_bits_r <= `CPLS_RST_LOW;
    end else if (core_upd.load) begin
      priority_level_low_bits_r <= core_upd.level[2:0];
    end else if (wr_status && !nesting_disable_r) begin
      priority_level_low_bits_r <=
        acc.wdata[`CPLS_STATUS_LOW_MSB:`CPLS_STATUS_LOW_LSB];
    end
  end

  // ---------------------------------------------------------------
  // Priority level high bit
  // ---------------------------------------------------------------
  // Set only by the core; software may clear it but never set it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      priority_level_high_bit_r <= `CPLS_RST_HIGH;
    end else if (core_upd.load) begin
      priority_level_high_bit_r <= core_upd.level[3];
    end else if (wr_core && !acc.wdata[`CPLS_CORE_HIGH_BIT]) begin
      priority_level_high_bit_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Latency select and nesting disable
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      var_latency_r <= `CPLS_RST_VAR;
    end else if (wr_core) begin
      var_latency_r <= acc.wdata[`CPLS_CORE_VAR_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nesting_disable_r <= `CPLS_RST_NEST;
    end else if (wr_trap) begin
      nesting_disable_r <= acc.wdata[`CPLS_TRAP_NEST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Accumulator and trap flag bits are not held here and read zero
  always_comb begin
    rdata = 16'h0000;
    case (acc.addr)
      `CPLS_OFS_STATUS: rdata[`CPLS_STATUS_LOW_MSB:`CPLS_STATUS_LOW_LSB] =
        priority_level_low_bits_r;
      `CPLS_OFS_CORE: begin
        rdata[`CPLS_CORE_VAR_BIT] = var_latency_r;
        rdata[`CPLS_CORE_HIGH_BIT] = priority_level_high_bit_r;
      end
      `CPLS_OFS_TRAP: rdata[`CPLS_TRAP_NEST_BIT] = nesting_disable_r;
      default: rdata = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Interrupt gate and outputs
  // ---------------------------------------------------------------
  cpls_level_cmp u_cmp (
    .level({priority_level_high_bit_r, priority_level_low_bits_r}),
    .req(user_req),
    .allow(allow)
  );

  // Registered so every output comes from a flop; adds one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_forward <= 1'b0;
      cpu_level <= 4'h0;
      variable_latency <= 1'b0;
      nesting_disable <= 1'b0;
    end else begin
      irq_forward <= allow;
      cpu_level <= {priority_level_high_bit_r, priority_level_low_bits_r};
      variable_latency <= var_latency_r;
      nesting_disable <= nesting_disable_r;
    end
  end

endmodule
`default_nettype wire

// [verilog/cpls_params.svh]
// Offsets, field positions and reset values of the priority level block
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`ifndef CPLS_PARAMS_SVH
`define CPLS_PARAMS_SVH

// Register byte offsets
`define CPLS_OFS_STATUS 8'h00
`define CPLS_OFS_CORE 8'h04
`define CPLS_OFS_TRAP 8'h08

// Field positions
`define CPLS_STATUS_LOW_LSB 5
`define CPLS_STATUS_LOW_MSB 7
`define CPLS_CORE_VAR_BIT 15
`define CPLS_CORE_HIGH_BIT 3
`define CPLS_TRAP_NEST_BIT 15

// Reset values
`define CPLS_RST_LOW 3'h0
`define CPLS_RST_HIGH 1'b0
`define CPLS_RST_VAR 1'b0
`define CPLS_RST_NEST 1'b0

// Level that refuses all user interrupts in the low bits
`define CPLS_LOW_ALL_MASKED 3'h7

`endif

// [verilog/cpls_pkg.sv]
// Types shared by the priority level block
package cpls_pkg;

  // Register access handed from the bus slave to the register file
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cpls_acc_t;

  // Level update requested by the core on exception entry or return
  typedef struct packed {
    logic load;
    logic [3:0] level;
  } cpls_core_upd_t;

  // User interrupt request offered for forwarding
  typedef struct packed {
    logic pending;
    logic [2:0] priority_lvl;
  } cpls_user_req_t;

  // Bus slave sequence, Gray coded from IDLE through WAIT to DONE; DONE back to IDLE flips both bits
  typedef enum logic [1:0] {
    CPLS_IDLE = 2'b00,
    CPLS_WAIT = 2'b01,
    CPLS_DONE = 2'b11
  } cpls_state_t;

endpackage

// [verilog/cpls_ahb_slave.sv]
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
module cpls_ahb_slave (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Register file side
  output cpls_pkg::cpls_acc_t acc,
  input wire logic [15:0] rdata
);
  import cpls_pkg::*;

  cpls_state_t state_r;
  logic [7:0] addr_r;
  logic write_r;
  logic start;

  // New transfer seen in an address phase
  assign start = hsel && hready && htrans[1];

  // Access pulse in the wait cycle; write data is on the bus by then
  assign acc = '{valid: (state_r == CPLS_WAIT), write: write_r, addr: addr_r,
                 wdata: hwdata[15:0]};

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  // The wait state lets a read see a write that ended just before it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= CPLS_IDLE;
      hreadyout <= 1'b1;
    end else begin
      case (state_r)
        CPLS_IDLE, CPLS_DONE: begin
          if (start) begin
            state_r <= CPLS_WAIT;
            hreadyout <= 1'b0;
          end else begin
            state_r <= CPLS_IDLE;
          end
        end
        CPLS_WAIT: begin
          state_r <= CPLS_DONE;
          hreadyout <= 1'b1;
        end
        default: begin
          state_r <= CPLS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Address phase capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_r <= 8'h00;
      write_r <= 1'b0;
    end else if (start && state_r != CPLS_WAIT) begin
      addr_r <= haddr[7:0];
      write_r <= hwrite;
    end
  end

  // Read data and response; narrow registers sit in the low half
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else if (state_r == CPLS_WAIT) begin
      hrdata <= write_r ? 32'h0000_0000 : {16'h0000, rdata};
    end
  end

endmodule
`default_nettype wire

// [verilog/cpls_level_cmp.sv]
// User interrupt gate against the current priority level
`timescale 1ns/1ps
`default_nettype none
`include "cpls_params.svh"
module cpls_level_cmp (
  // Current level and request
  input wire logic [3:0] level,
  input wire cpls_pkg::cpls_user_req_t req,
  // Decision
  output logic allow
);
  import cpls_pkg::*;

  // Strict greater-than against the whole four-bit level
  function automatic logic user_allowed(input logic [3:0] lvl, input logic [2:0] prio);
    user_allowed = ({1'b0, prio} > lvl);
  endfunction

  // High bit or low bits at 111 shut every user source out
  always_comb begin
    allow = 1'b0;
    if (req.pending && !level[3]
        && level[2:0] != `CPLS_LOW_ALL_MASKED
        && user_allowed(level, req.priority_lvl)) begin
      allow = 1'b1;
    end
  end

endmodule
`default_nettype wire

// [sim/cpls_top_assertions.sv]
// Port checker of the priority level block
`timescale 1ns/1ps
`default_nettype none
module cpls_top_assertions (
  // Clock, reset and bus
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Core side
  input wire cpls_pkg::cpls_core_upd_t core_upd,
  input wire cpls_pkg::cpls_user_req_t user_req,
  input wire logic irq_forward,
  input wire logic [3:0] cpu_level,
  input wire logic variable_latency,
  input wire logic nesting_disable
);
  import cpls_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic live_r;
  logic wr_w;
  // ----
  // Helpers
  // ----
  // First edge after reset still sees reset history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) live_r <= 1'h0;
    else live_r <= 1'h1;
  end
  // Write address phase taken
  assign wr_w = hsel && hready && htrans[1] && hwrite;
  // ----
  // Properties
  // ----
  property p_gate;
    live_r |-> irq_forward == ($past(user_req.pending) &&
      {1'h0, $past(user_req.priority_lvl)} > cpu_level);
  endproperty
  a_gate: assert property (p_gate) else $error("forward differs from gate");
  property p_masked;
    live_r && cpu_level[2:0] == 3'h7 |-> !irq_forward;
  endproperty
  a_masked: assert property (p_masked) else $error("forward at low level 7");
  property p_high;
    cpu_level[3] |-> !irq_forward;
  endproperty
  a_high: assert property (p_high) else $error("forward with high bit set");
  // State moves at the taking edge; the registered output shows it two samples on
  property p_load;
    core_upd.load |-> ##2 cpu_level == $past(core_upd.level, 2);
  endproperty
  a_load: assert property (p_load) else $error("loaded level not shown");
  property p_rise;
    $rose(cpu_level[3]) |-> $past(core_upd.load, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("high bit set without load");
  property p_low;
    wr_w && haddr[7:0] == 8'h00 && !nesting_disable ##1 !core_upd.load
      |-> ##2 cpu_level[2:0] == $past(hwdata[7:5], 2);
  endproperty
  a_low: assert property (p_low) else $error("low bits not written");
  property p_lock;
    wr_w && haddr[7:0] == 8'h00 && nesting_disable && !core_upd.load ##1 !core_upd.load
      |-> ##2 $stable(cpu_level[2:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked low bits changed");
  property p_var;
    wr_w && haddr[7:0] == 8'h04 |-> ##3 variable_latency == $past(hwdata[15], 2);
  endproperty
  a_var: assert property (p_var) else $error("latency bit not written");
  // Main scenarios reached
  c_write: cover property (wr_w);
  c_fwd: cover property (irq_forward);
  c_high: cover property (cpu_level[3]);
endmodule
bind cpls_top cpls_top_assertions u_cpls_top_assertions (.clock, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .core_upd, .user_req, .irq_forward, .cpu_level, .variable_latency,
  .nesting_disable);
`default_nettype wire

// [sim/tb_cpu_priority_level_status.sv]
// Self-checking bench of the priority level block
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_priority_level_status;
  import cpls_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  cpls_core_upd_t core_upd = '0;
  cpls_user_req_t user_req = '0;
  logic irq_forward;
  logic [3:0] cpu_level;
  logic variable_latency;
  logic nesting_disable;
  logic [31:0] rd;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Single slave, so its ready is the bus ready
  cpls_top u_cpls_top (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .core_upd, .user_req, .irq_forward,
    .cpu_level, .variable_latency, .nesting_disable);
  // Clock
  initial begin
    forever #4 clock = ~clock;
  end
  // Hang guard, far above the run length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One word transfer; read data lands in rd
  // Select stays up between calls; htrans IDLE alone marks no transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic t_reset();
    bus(1'h1, 8'h0C, 32'hFFFF_FFFF);
    for (int a = 0; a < 16; a += 4) begin
      bus(1'h0, 8'(a), 32'h0000_0000);
      chk("reset word", 32'h0000_0000, rd);
    end
  endtask
  task automatic t_low();
    for (int l = 0; l < 8; l++) begin
      bus(1'h1, 8'h00, 32'(l) << 5);
      bus(1'h0, 8'h00, 32'h0000_0000);
      chk("status word", 32'(l) << 5, rd);
      chk("level", 32'(l), 32'(cpu_level));
      for (int p = 0; p < 8; p++) begin
        user_req <= '{1'h1, 3'(p)};
        repeat (2) @(posedge clock);
        chk("forward", 32'(p > l), 32'(irq_forward));
      end
      user_req <= '0;
    end
  endtask
  task automatic t_high();
    core_upd <= '{1'h1, 4'hA};
    @(posedge clock);
    core_upd <= '0;
    repeat (2) @(posedge clock);
    chk("loaded level", 32'h0000_000A, 32'(cpu_level));
    user_req <= '{1'h1, 3'h7};
    bus(1'h0, 8'h04, 32'h0000_0000);
    chk("core word", 32'h0000_0008, rd);
    chk("forward high", 32'h0000_0000, 32'(irq_forward));
    bus(1'h1, 8'h04, 32'h0000_0000);
    bus(1'h1, 8'h04, 32'h0000_0008);
    @(posedge clock);
    chk("cleared level", 32'h0000_0002, 32'(cpu_level));
    user_req <= '0;
  endtask
  task automatic t_var();
    bus(1'h1, 8'h04, 32'h0000_8000);
    bus(1'h0, 8'h04, 32'h0000_0000);
    chk("core word", 32'h0000_8000, rd);
    chk("latency", 32'h0000_0001, 32'(variable_latency));
    bus(1'h1, 8'h04, 32'h0000_0000);
  endtask
  task automatic t_nest();
    bus(1'h1, 8'h08, 32'h0000_8000);
    bus(1'h1, 8'h00, 32'h0000_00E0);
    bus(1'h0, 8'h00, 32'h0000_0000);
    chk("locked status", 32'h0000_0040, rd);
    chk("response", 32'h0000_0000, 32'(hresp));
    chk("nesting", 32'h0000_0001, 32'(nesting_disable));
    bus(1'h1, 8'h08, 32'h0000_0000);
    bus(1'h1, 8'h00, 32'h0000_00E0);
    bus(1'h0, 8'h00, 32'h0000_0000);
    chk("open status", 32'h0000_00E0, rd);
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    t_reset();
    t_low();
    t_high();
    t_var();
    t_nest();
    finish_test();
  end
endmodule
`default_nettype wire
